// [shared/twst_consts.svh]
// constants for the two-wire slave transmitter status block
// assumes inclusion by bare name from design files
`ifndef TWST_CONSTS_SVH
`define TWST_CONSTS_SVH

// register indices on the plain register port
`define TWST_ADDR_CTRL      2'h0
`define TWST_ADDR_STATUS    2'h1
`define TWST_ADDR_DATA      2'h2
`define TWST_ADDR_OWNADR    2'h3

// control register bit positions
`define TWST_CTRL_DONE      7
`define TWST_CTRL_ACKEN     6
`define TWST_CTRL_START     5
`define TWST_CTRL_STOP      4
`define TWST_CTRL_ENABLE    2
`define TWST_CTRL_RESET     8'h00

// own-address register: bits 7:1 address, bit 0 general call enable
`define TWST_OWNADR_RESET   8'h00

// status codes, prescaler field always zero
`define TWST_ST_OWN_ADDRESS_READ       8'hA8
`define TWST_ST_ARB_OWN_ADDRESS_READ   8'hB0
`define TWST_ST_DATA_ACK    8'hB8
`define TWST_ST_DATA_NACK   8'hC0
`define TWST_ST_LAST_ACK    8'hC8
`define TWST_ST_IDLE        8'hF8
`define TWST_ST_BUS_ERR     8'h00
`define TWST_STATUS_MASK    8'hF8

`endif

// [shared/twst_pkg.sv]
// types for the two-wire slave transmitter status block
// assumes nothing beyond a SystemVerilog compiler
package twst_pkg;
    // frame position of the serial engine, one-hot
    typedef enum logic [5:0] {
        TWST_IDLE  = 6'b000001,  // not addressed, watching
        TWST_ADDR  = 6'b000010,  // shifting address byte in
        TWST_AACK  = 6'b000100,  // driving address acknowledge
        TWST_HOLD  = 6'b001000,  // job done or bus error, scl held low except on bus error
        TWST_DATA  = 6'b010000,  // shifting data byte out
        TWST_DACK  = 6'b100000   // sampling master acknowledge
    } twst_state_t;
endpackage

// [verilog/twst_sync.sv]
// two-flop synchroniser for pins entering the core clock domain
// assumes asynchronous inputs, one bit each
`timescale 1ns/1ps
`default_nettype none
module twst_sync
(
    input  wire logic CORE_CLK,   // core clock
    input  wire logic RESET,      // synchronous, active high
    input  wire logic d,          // asynchronous level
    output logic      q           // synchronised level
);
    logic meta_reg;               // first stage, read only by q

    // idle-high bus lines reset to one
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            meta_reg <= 1'b1;
            q        <= 1'b1;
        end
        else
        begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule // twst_sync
`default_nettype wire

// [verilog/twst_slave_tx.sv]
// two-wire slave transmitter with status codes and bus error recovery
// assumes scl/sda open drain, external pull-ups, scl far below core clock
`timescale 1ns/1ps
`default_nettype none
`include "twst_consts.svh"
//
// Contract
// - own read address acked gives 0xA8
// - arbitration lost then addressed gives 0xB0
// - data acked gives 0xB8, send next
// - data nacked gives 0xC0, then unaddressed
// - last byte acked gives 0xC8, unaddressed
// - leaving with ack off ignores all addresses
// - leaving with ack on answers own address
// - general call only when enable set
// - start request leaves then starts when free; code only raises START_PENDING while the bus is busy, sends no start
// - status 0xF8 while done flag clear
// - misplaced start/stop is bus error 0x00
// - bus error sets done flag
// - recovery unaddresses, clears stop only
// - recovery releases lines, no stop sent
// - status prescaler bits read zero
// - done flag holds scl low; code leaves scl released while status is 0x00
// - unaddressed device leaves sda released
module twst_slave_tx
(
    input  wire logic       CORE_CLK,      // core clock, 50 MHz
    input  wire logic       RESET,         // synchronous, active high
    input  wire logic [1:0] ADDR,          // register index
    input  wire logic [7:0] WDATA,         // write data
    input  wire logic       WR,            // write strobe
    input  wire logic       RD,            // read strobe
    output logic      [7:0] RDATA,         // read data, cycle after RD
    input  wire logic       ARB_LOST,      // master lost arbitration
    input  wire logic       SCL_I,         // scl pin level
    output logic            SCL_O,         // scl drive value, always 0
    output logic            SCL_OE,        // high while pulling scl low
    input  wire logic       SDA_I,         // sda pin level
    output logic            SDA_O,         // sda drive value, always 0
    output logic            SDA_OE,        // high while pulling sda low
    output logic            START_PENDING  // start waits for free bus
);
    logic        scl_s;                 // synchronised scl
    logic        sda_s;                 // synchronised sda
    logic        scl_d_reg;             // previous scl
    logic        sda_d_reg;             // previous sda
    logic [7:0]  ctrl_reg;              // control register
    logic [7:0]  own_reg;               // own address and gc enable
    logic [7:0]  shift_reg;             // shift byte register
    logic [7:0]  status_reg;            // status code
    logic [3:0]  bit_cnt_reg;           // bit count in byte
    logic        last_reg;              // byte sent with ack off
    logic        arb_reg;               // arbitration loss latched
    logic        busy_reg;              // bus between start and stop
    twst_pkg::twst_state_t state_reg;   // frame position
    logic        scl_rise;              // scl rising edge
    logic        scl_fall;              // scl falling edge
    logic        start_cond;            // sda falls with scl high
    logic        stop_cond;             // sda rises with scl high
    logic        done_wr;               // software writes one to done
    logic        in_frame;              // mid byte or acknowledge

    // pins cross into the core domain first
    twst_sync u_scl_sync
    (
        .CORE_CLK (CORE_CLK),
        .RESET    (RESET),
        .d        (SCL_I),
        .q        (scl_s)
    );
    twst_sync u_sda_sync
    (
        .CORE_CLK (CORE_CLK),
        .RESET    (RESET),
        .d        (SDA_I),
        .q        (sda_s)
    );

    // edge history of the synchronised lines
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end
        else
        begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    assign scl_rise   = scl_s & ~scl_d_reg;
    assign scl_fall   = ~scl_s & scl_d_reg;
    assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_cond  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
    assign done_wr    = WR && (ADDR == `TWST_ADDR_CTRL)
                        && WDATA[`TWST_CTRL_DONE];
    // address past bit 0, data or acknowledge in progress
    assign in_frame   = ((state_reg == twst_pkg::TWST_ADDR)
                         && (bit_cnt_reg != 4'h0))
                        || (state_reg == twst_pkg::TWST_DATA)
                        || (state_reg == twst_pkg::TWST_DACK)
                        || (state_reg == twst_pkg::TWST_AACK);

    // own address or general call match, gated by ack enable; general call also gated by gc enable
    function automatic logic addr_match(input logic [7:0] a,
                                        input logic [7:0] own,
                                        input logic ack_en);
        logic own_hit;
        logic gc_hit;
        own_hit = (a[7:1] == own[7:1]);
        gc_hit  = (a[7:1] == 7'h00) && own[0];
        addr_match = ack_en && (own_hit || gc_hit);
    endfunction

    // bus busy tracking for a deferred start
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
            busy_reg <= 1'b0;
        else if (start_cond)
            busy_reg <= 1'b1;
        else if (stop_cond)
            busy_reg <= 1'b0;
    end

    // start stays pending until the bus is free
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
            START_PENDING <= 1'b0;
        else
            START_PENDING <= ctrl_reg[`TWST_CTRL_START]
                             && (state_reg == twst_pkg::TWST_IDLE)
                             && !ctrl_reg[`TWST_CTRL_DONE]
                             && busy_reg;
    end

    // control register; hardware set of done wins over software clear
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
            ctrl_reg <= `TWST_CTRL_RESET;
        else
        begin
            if (WR && ADDR == `TWST_ADDR_CTRL)
            begin
                // done clears only by writing one
                ctrl_reg[6:0] <= WDATA[6:0];
                if (done_wr)
                    ctrl_reg[`TWST_CTRL_DONE] <= 1'b0;
            end
            // recovery: stop bit self clears, other bits take the written value
            if (ctrl_reg[`TWST_CTRL_DONE] && done_wr
                && WDATA[`TWST_CTRL_STOP]
                && status_reg == `TWST_ST_BUS_ERR)
                ctrl_reg[`TWST_CTRL_STOP] <= 1'b0;
            // a misplaced start or stop sets done
            if (in_frame && (start_cond || stop_cond))
                ctrl_reg[`TWST_CTRL_DONE] <= 1'b1;
            else if ((state_reg == twst_pkg::TWST_AACK && scl_fall)
                     || (state_reg == twst_pkg::TWST_DACK && scl_rise))
                ctrl_reg[`TWST_CTRL_DONE] <= 1'b1;
        end
    end

    // own address register
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
            own_reg <= `TWST_OWNADR_RESET;
        else if (WR && ADDR == `TWST_ADDR_OWNADR)
            own_reg <= WDATA;
    end

    // arbitration loss latched until the next own address acknowledge completes
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
            arb_reg <= 1'b0;
        else if (ARB_LOST)
            arb_reg <= 1'b1;
        else if (state_reg == twst_pkg::TWST_AACK && scl_fall)
            arb_reg <= 1'b0;
    end

    // frame engine and status codes
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            state_reg   <= twst_pkg::TWST_IDLE;
            status_reg  <= `TWST_ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg   <= 8'h00;
            last_reg    <= 1'b0;
        end
        else if (in_frame && (start_cond || stop_cond))
        begin
            state_reg  <= twst_pkg::TWST_HOLD;
            status_reg <= `TWST_ST_BUS_ERR;
        end
        else
        begin
            if (WR && ADDR == `TWST_ADDR_DATA && ctrl_reg[`TWST_CTRL_DONE])
                shift_reg <= WDATA;
            unique case (state_reg)
                twst_pkg::TWST_IDLE:
                begin
                    // unaddressed: sda stays released
                    if (start_cond)
                    begin
                        state_reg   <= twst_pkg::TWST_ADDR;
                        bit_cnt_reg <= 4'h0;
                    end
                end
                twst_pkg::TWST_ADDR:
                begin
                    if (start_cond)
                        bit_cnt_reg <= 4'h0;
                    else if (scl_rise)
                    begin
                        shift_reg   <= {shift_reg[6:0], sda_s};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    else if (scl_fall && bit_cnt_reg == 4'h8)
                    begin
                        // only read direction served here
                        if (shift_reg[0]
                            && addr_match(shift_reg, own_reg,
                                          ctrl_reg[`TWST_CTRL_ACKEN]))
                        begin
                            state_reg  <= twst_pkg::TWST_AACK;
                        end
                        else
                            state_reg <= twst_pkg::TWST_IDLE;
                    end
                end
                twst_pkg::TWST_AACK:
                begin
                    // ack bit driven; report on its falling edge
                    if (scl_fall)
                    begin
                        state_reg  <= twst_pkg::TWST_HOLD;
                        status_reg <= arb_reg ? `TWST_ST_ARB_OWN_ADDRESS_READ
                                              : `TWST_ST_OWN_ADDRESS_READ;
                    end
                end
                twst_pkg::TWST_HOLD:
                begin
                    // released by writing one to done
                    if (done_wr)
                    begin
                        status_reg <= `TWST_ST_IDLE;
                        if (status_reg == `TWST_ST_DATA_NACK
                            || status_reg == `TWST_ST_LAST_ACK
                            || status_reg == `TWST_ST_BUS_ERR)
                            state_reg <= twst_pkg::TWST_IDLE;
                        else
                        begin
                            state_reg   <= twst_pkg::TWST_DATA;
                            bit_cnt_reg <= 4'h0;
                            last_reg    <= !WDATA[`TWST_CTRL_ACKEN];
                        end
                    end
                end
                twst_pkg::TWST_DATA:
                begin
                    // next bit moves out on each falling edge
                    if (scl_fall)
                    begin
                        if (bit_cnt_reg == 4'h7)
                            state_reg <= twst_pkg::TWST_DACK;
                        else
                        begin
                            shift_reg   <= {shift_reg[6:0], 1'b1};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                    end
                end
                twst_pkg::TWST_DACK:
                begin
                    // ninth clock: sample master answer
                    if (scl_rise)
                    begin
                        state_reg <= twst_pkg::TWST_HOLD;
                        if (sda_s)
                            status_reg <= `TWST_ST_DATA_NACK;
                        else if (last_reg)
                            status_reg <= `TWST_ST_LAST_ACK;
                        else
                            status_reg <= `TWST_ST_DATA_ACK;
                    end
                end
                default:
                    state_reg <= twst_pkg::TWST_IDLE;
            endcase
        end
    end

    // line drivers; only low is ever driven
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            SCL_O  <= 1'b0;
            SDA_O  <= 1'b0;
            SCL_OE <= 1'b0;
            SDA_OE <= 1'b0;
        end
        else
        begin
            SCL_O  <= 1'b0;
            SDA_O  <= 1'b0;
            // stretch scl low while waiting for software
            SCL_OE <= (state_reg == twst_pkg::TWST_HOLD)
                      && ctrl_reg[`TWST_CTRL_DONE]
                      && status_reg != `TWST_ST_BUS_ERR;
            SDA_OE <= (state_reg == twst_pkg::TWST_AACK)
                      || ((state_reg == twst_pkg::TWST_DATA)
                          && !shift_reg[7]);
        end
    end

    // register read port, data one cycle after strobe
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
            RDATA <= 8'h00;
        else if (RD)
        begin
            unique case (ADDR)
                `TWST_ADDR_CTRL:   RDATA <= ctrl_reg;
                `TWST_ADDR_STATUS: RDATA <= ctrl_reg[`TWST_CTRL_DONE]
                                   ? (status_reg & `TWST_STATUS_MASK)
                                   : `TWST_ST_IDLE;
                `TWST_ADDR_DATA:   RDATA <= shift_reg;
                `TWST_ADDR_OWNADR: RDATA <= own_reg;
            endcase
        end
        else
            RDATA <= 8'h00;
    end

    // checks
    status_idle_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        RD && ADDR == `TWST_ADDR_STATUS && !ctrl_reg[`TWST_CTRL_DONE]
        |=> RDATA == `TWST_ST_IDLE)
        else $error("status not idle with done clear");
    prescale_zero_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        RD && ADDR == `TWST_ADDR_STATUS |=> RDATA[2:0] == 3'h0)
        else $error("prescaler bits not zero");
    bus_err_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        in_frame && (start_cond || stop_cond)
        |=> status_reg == `TWST_ST_BUS_ERR
        && ctrl_reg[`TWST_CTRL_DONE])
        else $error("bus error not reported");
    err_release_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        status_reg == `TWST_ST_BUS_ERR |=> !SCL_OE)
        else $error("scl held in bus error");
    stretch_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        state_reg == twst_pkg::TWST_HOLD && ctrl_reg[`TWST_CTRL_DONE]
        && status_reg != `TWST_ST_BUS_ERR |=> SCL_OE)
        else $error("scl not stretched");
    idle_quiet_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        state_reg == twst_pkg::TWST_IDLE |=> !SDA_OE)
        else $error("sda driven while unaddressed");
    nack_code_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        state_reg == twst_pkg::TWST_DACK && scl_rise && sda_s
        |=> status_reg == `TWST_ST_DATA_NACK)
        else $error("nack code wrong");
    leave_idle_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        state_reg == twst_pkg::TWST_HOLD && done_wr
        && status_reg == `TWST_ST_LAST_ACK
        |=> state_reg == twst_pkg::TWST_IDLE)
        else $error("not unaddressed after last byte");
    cov_read_c: cover property (@(posedge CORE_CLK)
        status_reg == `TWST_ST_OWN_ADDRESS_READ);
    cov_ack_c: cover property (@(posedge CORE_CLK)
        status_reg == `TWST_ST_DATA_ACK);
    cov_err_c: cover property (@(posedge CORE_CLK)
        status_reg == `TWST_ST_BUS_ERR);
endmodule // twst_slave_tx
`default_nettype wire

// [tb/twst_master_model.sv]
// behavioural remote master receiver on the two-wire bus
// assumes the bench resolves scl/sda with pull-ups, 160 ns bit period
`timescale 1ns/1ps
`default_nettype none
module twst_master_model
(
    input  wire logic scl,     // resolved scl level
    input  wire logic sda,     // resolved sda level
    output logic      scl_oe,  // high while pulling scl low
    output logic      sda_oe   // high while pulling sda low
);
    // both lines released at power up
    initial
    begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end

    // high phase; the slave may stretch low, so wait for the wire
    task automatic clock_high(output logic s);
        scl_oe = 1'b0;
        wait (scl === 1'b1);
        #40;
        s = sda;
        #40;
        scl_oe = 1'b1;
        #40;
    endtask

    // one bit, sda only changes while scl is low
    task automatic bit_cycle(input logic b, output logic s);
        sda_oe = ~b;
        #40;
        clock_high(s);
    endtask

    // start: sda falls while scl high; odd offset breaks phase lock
    task automatic start_cond();
        #7;
        sda_oe = 1'b1;
        #80;
        scl_oe = 1'b1;
        #40;
    endtask

    // stop: sda rises while scl high
    task automatic stop_cond();
        sda_oe = 1'b1;
        #40;
        scl_oe = 1'b0;
        wait (scl === 1'b1);
        #80;
        sda_oe = 1'b0;
        #80;
    endtask

    // seven address bits, direction, then sample the acknowledge
    task automatic send_addr(input logic [6:0] a, input logic rw,
                             output logic ack);
        logic s;
        for (int i = 6; i >= 0; i--)
            bit_cycle(a[i], s);
        bit_cycle(rw, s);
        bit_cycle(1'b1, ack);
    endtask

    // eight data bits msb first, then our acknowledge choice
    task automatic read_byte(input logic mack, output logic [7:0] d);
        logic s;
        // step off the core clock grid: a scl rise landing on the same
        // edge as the slave's sda move would look like start or stop
        #3;
        for (int i = 7; i >= 0; i--)
            bit_cycle(1'b1, d[i]);
        bit_cycle(~mack, s);
        sda_oe = 1'b0;
    endtask
endmodule // twst_master_model
`default_nettype wire

// [tb/tb_two_wire_slave_tx_status.sv]
// self-checking bench for the slave transmitter status block
// assumes the master model and the consts header on the include path
`timescale 1ns/1ps
`default_nettype none
`include "twst_consts.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module tb_two_wire_slave_tx_status;
    typedef struct packed {
        logic       fresh;  // new transfer before this byte
        logic       arb;    // arbitration lost first
        logic [7:0] data;   // byte loaded by software
        logic       ack_en; // more bytes wanted
        logic       mack;   // master acknowledges
        logic [7:0] exp;    // status after the byte
    } twst_row_t;
    localparam logic [6:0] OWN7 = 7'h2A;  // own address
    logic       core_clk = 1'b0;  // 50 MHz
    logic       reset    = 1'b1;  // held 12 cycles
    logic [1:0] addr     = 2'h0;  // register index
    logic [7:0] wdata    = 8'h00; // write data
    logic       wr       = 1'b0;  // write strobe
    logic       rd       = 1'b0;  // read strobe
    logic       arb_lost = 1'b0;  // arbitration pulse
    logic [7:0] rdata;            // read data
    logic       scl_o, scl_oe, sda_o, sda_oe, start_pending;
    logic       m_scl_oe, m_sda_oe;   // master drives
    wire        scl_w = (scl_oe ? scl_o : 1'b1) & ~m_scl_oe; // pull-up
    wire        sda_w = (sda_oe ? sda_o : 1'b1) & ~m_sda_oe; // pull-up
    int         num_errors = 0;
    int         samples_checked = 0;
    int         cycles = 0;
    logic [7:0] d;
    logic       ack, s;
    twst_row_t  rows [0:2] = '{
        '{1'b1, 1'b0, 8'h3C, 1'b1, 1'b1, `TWST_ST_DATA_ACK},
        '{1'b0, 1'b0, 8'hA5, 1'b0, 1'b1, `TWST_ST_LAST_ACK},
        '{1'b1, 1'b1, 8'h81, 1'b1, 1'b0, `TWST_ST_DATA_NACK}};

    twst_slave_tx dut_u (.CORE_CLK(core_clk), .RESET(reset), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .ARB_LOST(arb_lost), .SCL_I(scl_w), .SCL_O(scl_o),
        .SCL_OE(scl_oe), .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE(sda_oe),
        .START_PENDING(start_pending));
    twst_master_model mst_u (.scl(scl_w), .sda(sda_w),
        .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));

    // core clock
    always #10 core_clk = ~core_clk;

    // verdict, reached once
    task automatic tally_and_finish();
        if (num_errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // hang guard, far above the thousand or so cycles needed
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end

    // one-cycle register write
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
        @(posedge core_clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge core_clk);
        wr    <= 1'b0;
    endtask

    // one-cycle read, data taken once the answer edge has settled
    task automatic rd_reg(input logic [1:0] a, output logic [7:0] v);
        @(posedge core_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge core_clk);
        rd   <= 1'b0;
        #1;
        v = rdata;
    endtask

    // poll the done flag, bounded, since pins cross a synchroniser
    task automatic wait_done();
        logic [7:0] c;
        c = 8'h00;
        for (int k = 0; k < 40 && !c[7]; k++)
            rd_reg(`TWST_ADDR_CTRL, c);
        `CHK(c[7], 1'b1)
    endtask

    // address the device for reading, expect the given status
    task automatic open_read(input logic [7:0] st);
        mst_u.start_cond();
        mst_u.send_addr(OWN7, 1'b1, ack);
        `CHK(ack, 1'b0)
        wait_done();
        rd_reg(`TWST_ADDR_STATUS, d);
        `CHK(d, st)
        `CHK(scl_oe, 1'b1)
    endtask

    // software loads a byte, master reads it
    task automatic send_byte(input logic [7:0] v, input logic ae,
                             input logic mack);
        wr_reg(`TWST_ADDR_DATA, v);
        wr_reg(`TWST_ADDR_CTRL, {1'b1, ae, 6'h04});
        mst_u.read_byte(mack, d);
        `CHK(d, v)
        wait_done();
        rd_reg(`TWST_ADDR_STATUS, d);
    endtask

    // main sequence
    initial
    begin
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        rd_reg(`TWST_ADDR_STATUS, d);
        `CHK(d, `TWST_ST_IDLE)
        rd_reg(`TWST_ADDR_CTRL, d);
        `CHK(d, `TWST_CTRL_RESET)
        wr_reg(`TWST_ADDR_OWNADR, {OWN7, 1'b0});
        wr_reg(`TWST_ADDR_CTRL, 8'h44);
        // ordinary transfers from the table
        foreach (rows[i])
        begin
            if (rows[i].arb)
            begin
                @(posedge core_clk);
                arb_lost <= 1'b1;
                @(posedge core_clk);
                arb_lost <= 1'b0;
            end
            if (rows[i].fresh)
                open_read(rows[i].arb ? `TWST_ST_ARB_OWN_ADDRESS_READ
                                      : `TWST_ST_OWN_ADDRESS_READ);
            send_byte(rows[i].data, rows[i].ack_en, rows[i].mack);
            `CHK(d, rows[i].exp)
            if (rows[i].exp !== `TWST_ST_DATA_ACK)
            begin
                wr_reg(`TWST_ADDR_CTRL, 8'hC4);
                mst_u.stop_cond();
                rd_reg(`TWST_ADDR_STATUS, d);
                `CHK(d, `TWST_ST_IDLE)
            end
        end
        // last byte acked anyway, leave with acks off
        open_read(`TWST_ST_OWN_ADDRESS_READ);
        send_byte(8'h5A, 1'b0, 1'b1);
        `CHK(d, `TWST_ST_LAST_ACK)
        wr_reg(`TWST_ADDR_CTRL, 8'h84);
        mst_u.read_byte(1'b0, d);
        `CHK(d, 8'hFF)
        mst_u.stop_cond();
        mst_u.start_cond();
        mst_u.send_addr(OWN7, 1'b1, ack);
        `CHK(ack, 1'b1)
        mst_u.stop_cond();
        wr_reg(`TWST_ADDR_CTRL, 8'h44);
        // general call ignored while its enable is clear
        mst_u.start_cond();
        mst_u.send_addr(7'h00, 1'b1, ack);
        `CHK(ack, 1'b1)
        mst_u.stop_cond();
        // stop in mid address byte, then recovery
        mst_u.start_cond();
        repeat (3) mst_u.bit_cycle(1'b1, s);
        mst_u.stop_cond();
        wait_done();
        rd_reg(`TWST_ADDR_STATUS, d);
        `CHK(d, `TWST_ST_BUS_ERR)
        wr_reg(`TWST_ADDR_CTRL, 8'hD4);
        rd_reg(`TWST_ADDR_CTRL, d);
        `CHK(d, 8'h44)
        `CHK({scl_oe, sda_oe}, 2'b00)
        // nack ends the read, leave asking for a start
        open_read(`TWST_ST_OWN_ADDRESS_READ);
        send_byte(8'hC3, 1'b0, 1'b0);
        `CHK(d, `TWST_ST_DATA_NACK)
        wr_reg(`TWST_ADDR_CTRL, 8'hA4);
        repeat (4) @(posedge core_clk);
        `CHK(start_pending, 1'b1)
        // bus frees up, nothing left to wait for
        mst_u.stop_cond();
        repeat (4) @(posedge core_clk);
        `CHK(start_pending, 1'b0)
        tally_and_finish();
    end
endmodule // tb_two_wire_slave_tx_status
`default_nettype wire
